// file: src/mpba_defines.vh
// Constants for the multiprocessor bus arbiter
`ifndef MPBA_DEFINES_VH
`define MPBA_DEFINES_VH
// Number of processors and request lines sharing the bus
`define MPBA_NUM_PROC      8
// Width of the processor identifier
`define MPBA_ID_W          3
// Reset value of all active-low request lines (inactive high)
`define MPBA_REQ_IDLE      8'hff
// Bit position of the master-indicator strap
`define MPBA_STRAP_MASTER  0
// Bit position of the bus-lock strap
`define MPBA_STRAP_LOCK    1
// Width of the captured strap word
`define MPBA_STRAP_W       2
// Last turnaround count; the bus stays idle for this many cycles plus one between owners
`define MPBA_TURN_CYCLES   2'h1
`endif

// file: src/mpba_sync.v
// Two-flop synchroniser for a group of level inputs
`timescale 1ns/100ps
module mpba_sync
#(
    parameter W    = 1,
    parameter INIT = 1'b1
)
(
    // Clock and reset
    input  wire         i_ref_clk,
    input  wire         i_srst,
    // Raw and synchronised levels
    input  wire [W-1:0] i_async,
    output reg  [W-1:0] o_sync
);
    reg [W-1:0] stage1; // First flop, read only by o_sync

    // ----------------------------------------
    // Synchroniser flops
    // ----------------------------------------
    always @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            stage1 <= {W{INIT}};
            o_sync <= {W{INIT}};
        end
        else
        begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule

// file: src/mpba_arbiter.v
// Multiprocessor external bus arbiter, device side
`timescale 1ns/100ps
`include "mpba_defines.vh"
module mpba_arbiter
(
    // Clock and reset
    input  wire       i_ref_clk,
    input  wire       i_srst,
    // Identity
    input  wire [2:0] i_processor_identifier,
    // Local requesters
    input  wire       i_core_req,
    input  wire       i_dma_req,
    input  wire       i_dma_hi_prio,
    input  wire       i_lock_req,
    input  wire       i_xact_busy,
    input  wire       i_sdram_sr_ack,
    // Shared request lines, active low
    input  wire [7:0] i_bus_request_lines_n,
    output reg  [7:0] o_bus_request_lines_n,
    output reg  [7:0] o_bus_request_lines_oe,
    // Host handshake, active low
    input  wire       i_host_bus_request_n,
    input  wire       i_back_off_input_n,
    input  wire       i_host_bus_grant_n,
    output reg        o_host_bus_grant_n,
    output reg        o_host_bus_grant_oe,
    // Priority lines, open drain, active low
    input  wire       i_core_priority_line_n,
    input  wire       i_dma_priority_line_n,
    output reg        o_core_priority_line_n,
    output reg        o_core_priority_line_oe,
    output reg        o_dma_priority_line_n,
    output reg        o_dma_priority_line_oe,
    // Indicator pins, also straps during reset
    input  wire       i_master_indicator_n,
    input  wire       i_bus_lock_indicator_n,
    output reg        o_master_indicator_n,
    output reg        o_bus_lock_indicator_n,
    output reg        o_bus_lock_indicator_oe,
    // Towards the local bus logic
    output reg        o_bus_granted,
    output reg        o_preempt,
    output reg        o_abort,
    output reg        o_bus_tristate,
    output reg        o_sdram_sr_req,
    output reg  [1:0] o_straps
);
    // ----------------------------------------
    // States, one-hot
    // ----------------------------------------
    localparam [5:0] ST_IDLE  = 6'h01; // Not owner
    localparam [5:0] ST_OWN   = 6'h02; // Owner, using bus
    localparam [5:0] ST_DRAIN = 6'h04; // Owner, finishing transaction
    localparam [5:0] ST_SREF  = 6'h08; // Putting SDRAM into self-refresh
    localparam [5:0] ST_HOST  = 6'h10; // Host holds the bus
    localparam [5:0] ST_TURN  = 6'h20; // Idle gap after release

    reg  [5:0] state;      // Current state
    reg  [5:0] next_state; // Next state
    reg  [1:0] turn_cnt;   // Turnaround count
    reg  [2:0] last_owner; // Most recent owner, for rotation
    reg  [2:0] my_id;      // Identifier captured at reset release
    reg        in_reset_d; // Reset seen last cycle

    wire [7:0] req_s;      // Synchronised request lines, active low
    wire       hbr_s;      // Synchronised host request, active low
    wire       back_off_input_s;     // Synchronised back-off, active low
    wire       hbg_s;      // Synchronised host grant, active low
    wire       cpa_s;      // Synchronised core priority, active low
    wire       dpa_s;      // Synchronised DMA priority, active low

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    mpba_sync #(.W(13), .INIT(1'b1)) u_sync
    (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .i_async   ({i_bus_request_lines_n, i_host_bus_request_n,
                     i_back_off_input_n, i_host_bus_grant_n,
                     i_core_priority_line_n, i_dma_priority_line_n}),
        .o_sync    ({req_s, hbr_s, back_off_input_s, hbg_s, cpa_s, dpa_s})
    );

    // Decode an identifier into a one-hot line select
    function [7:0] id_onehot;
        input [2:0] id;
        begin
            id_onehot = 8'h01 << id;
        end
    endfunction

    // Rotating winner: first requester after the last owner
    function [2:0] pick_winner;
        input [7:0] req;
        input [2:0] last;
        integer     k;
        reg   [2:0] cand;
        reg         found;
        begin
            pick_winner = last;
            found       = 1'b0;
            for (k = 1; k <= 8; k = k + 1)
            begin
                cand = last + k[2:0];
                if (!found && req[cand])
                begin
                    pick_winner = cand;
                    found       = 1'b1;
                end
            end
        end
    endfunction

    // Local need for the bus
    wire       want    = i_core_req | i_dma_req;
    // Active-high view of all requests, own line included
    wire [7:0] req_all = ~req_s;
    wire       any_req = |req_all;
    // Owner parks while its request stays up, else the rotation moves on
    wire [2:0] owner   = req_all[last_owner] ? last_owner :
                         pick_winner(req_all, last_owner);
    wire       win     = any_req && (owner == my_id);
    // Other processors' requests, own line masked out
    wire [7:0] others  = req_all & ~id_onehot(my_id);
    // Peer wants to preempt; only effective on lower-class own traffic
    wire       core_pre = ~cpa_s & ~i_core_req & ~o_core_priority_line_oe;
    wire       dma_pre  = ~dpa_s & ~i_core_req & ~i_dma_hi_prio &
                          ~o_dma_priority_line_oe;
    wire       host_req = ~hbr_s;
    wire       host_done = hbr_s;

    // ----------------------------------------
    // Identifier and strap capture
    // ----------------------------------------
    always @(posedge i_ref_clk)
    begin
        in_reset_d <= i_srst;
        if (i_srst)
        begin
            // Straps sampled while reset is held
            o_straps[`MPBA_STRAP_MASTER] <= i_master_indicator_n;
            o_straps[`MPBA_STRAP_LOCK]   <= i_bus_lock_indicator_n;
            my_id <= i_processor_identifier;
        end
        else if (in_reset_d)
        begin
            my_id <= i_processor_identifier;
        end
    end

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                // Only take the bus if the host is not holding it
                if (want && win && hbg_s && !host_req)
                    next_state = ST_OWN;
            end
            ST_OWN:
            begin
                if (!back_off_input_s)
                    next_state = ST_TURN;
                else if (host_req)
                    next_state = ST_DRAIN;
                else if (!want || core_pre || dma_pre)
                    next_state = ST_DRAIN;
                else if (!i_lock_req && (others != 8'h00))
                    next_state = ST_DRAIN;
            end
            ST_DRAIN:
            begin
                if (!back_off_input_s)
                    next_state = ST_TURN;
                else if (!i_xact_busy)
                    next_state = host_req ? ST_SREF : ST_TURN;
            end
            ST_SREF:
            begin
                if (i_sdram_sr_ack)
                    next_state = ST_HOST;
            end
            ST_HOST:
            begin
                if (host_done)
                    next_state = ST_TURN;
            end
            ST_TURN:
            begin
                if (turn_cnt == `MPBA_TURN_CYCLES)
                    next_state = ST_IDLE;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // State, counters and owner tracking
    // ----------------------------------------
    always @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            state      <= ST_IDLE;
            turn_cnt   <= 2'h0;
            last_owner <= 3'h7;
        end
        else
        begin
            state <= next_state;
            // Turnaround count restarts on entry
            if (state == ST_TURN)
                turn_cnt <= turn_cnt + 2'h1;
            else
                turn_cnt <= 2'h0;
            // Rotation pointer follows the owner; on a yield it moves past
            // us, so a waiting peer keeps the bus while it still requests
            if (state == ST_IDLE && any_req && hbg_s)
                last_owner <= owner;
            else if (state == ST_DRAIN && (others != 8'h00))
                last_owner <= pick_winner(others, my_id);
        end
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    always @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            o_bus_request_lines_n   <= `MPBA_REQ_IDLE;
            o_bus_request_lines_oe  <= 8'h00;
            o_host_bus_grant_n      <= 1'b1;
            o_host_bus_grant_oe     <= 1'b0;
            o_core_priority_line_n  <= 1'b0;
            o_core_priority_line_oe <= 1'b0;
            o_dma_priority_line_n   <= 1'b0;
            o_dma_priority_line_oe  <= 1'b0;
            o_master_indicator_n    <= 1'b1;
            o_bus_lock_indicator_n  <= 1'b1;
            o_bus_lock_indicator_oe <= 1'b0;
            o_bus_granted           <= 1'b0;
            o_preempt               <= 1'b0;
            o_abort                 <= 1'b0;
            o_bus_tristate          <= 1'b1;
            o_sdram_sr_req          <= 1'b0;
        end
        else
        begin
            // Own request line only, driven low while wanting the bus
            o_bus_request_lines_oe <= id_onehot(my_id);
            o_bus_request_lines_n  <= ~(id_onehot(my_id) &
                                        {8{want}});
            // Grant line driven only by the owner of the bus
            o_host_bus_grant_oe <= (next_state == ST_OWN) ||
                                   (next_state == ST_DRAIN) ||
                                   (next_state == ST_SREF) ||
                                   (next_state == ST_HOST);
            o_host_bus_grant_n  <= ~(next_state == ST_HOST);
            // Open drain: pull low, else release
            o_core_priority_line_n  <= 1'b0;
            o_core_priority_line_oe <= i_core_req;
            o_dma_priority_line_n   <= 1'b0;
            o_dma_priority_line_oe  <= i_dma_req &
                                       i_dma_hi_prio;
            // Debug master indicator
            o_master_indicator_n <= ~((next_state == ST_OWN) ||
                                      (next_state == ST_DRAIN));
            // Lock indication driven by owner only
            o_bus_lock_indicator_oe <= (next_state == ST_OWN) ||
                                       (next_state == ST_DRAIN);
            o_bus_lock_indicator_n  <= ~(i_lock_req &&
                                         (next_state == ST_OWN));
            // Local bus control
            o_bus_granted  <= (next_state == ST_OWN);
            o_preempt      <= (next_state == ST_DRAIN);
            o_abort        <= (state == ST_OWN || state == ST_DRAIN) &&
                              !back_off_input_s;
            o_bus_tristate <= !((next_state == ST_OWN) ||
                                (next_state == ST_DRAIN) ||
                                (next_state == ST_SREF));
            o_sdram_sr_req <= (next_state == ST_SREF) ||
                              (next_state == ST_HOST);
        end
    end
endmodule

// file: sim/mpba_arbiter_checker.sv
// Port checker for the multiprocessor bus arbiter
`timescale 1ns/100ps
module mpba_arbiter_checker
(
    // Inputs of the arbiter
    input wire       i_ref_clk, i_srst, i_core_req, i_dma_req,
    input wire       i_dma_hi_prio, i_host_bus_request_n,
    input wire       i_master_indicator_n, i_bus_lock_indicator_n,
    input wire [2:0] i_processor_identifier,
    // Outputs of the arbiter
    input wire [7:0] o_bus_request_lines_n, o_bus_request_lines_oe,
    input wire       o_host_bus_grant_n, o_host_bus_grant_oe,
    input wire       o_core_priority_line_n, o_core_priority_line_oe,
    input wire       o_dma_priority_line_n, o_dma_priority_line_oe,
    input wire       o_master_indicator_n, o_bus_lock_indicator_n,
    input wire       o_bus_lock_indicator_oe, o_bus_granted, o_abort,
    input wire       o_bus_tristate, o_sdram_sr_req,
    input wire [1:0] o_straps
);
    // ----------
    // Helpers
    // ----------
    wire [7:0] own_line   = 8'h01 << i_processor_identifier; // Own line
    wire       host_owned = ~o_host_bus_grant_n & o_host_bus_grant_oe;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    sequence s_sref_wait; o_sdram_sr_req && o_host_bus_grant_n; endsequence
    sequence s_hand_over; s_sref_wait ##1 host_owned; endsequence
    // ----------
    // Properties
    // ----------
    property p_own_line;
        (o_bus_request_lines_oe & ~own_line) == 8'h00; endproperty
    a_own_line: assert property (p_own_line) else $error("foreign line");
    property p_req_line; $rose(i_core_req) |=> o_bus_request_lines_oe ==
        own_line && (o_bus_request_lines_n & own_line) == 8'h00; endproperty
    a_req_line: assert property (p_req_line) else $error("bad line");
    property p_owner;
        o_bus_lock_indicator_oe == !o_master_indicator_n; endproperty
    a_owner: assert property (p_owner) else $error("owner flags");
    property p_lock;
        !o_bus_lock_indicator_n |-> o_bus_lock_indicator_oe; endproperty
    a_lock: assert property (p_lock) else $error("lock undriven");
    property p_hold; host_owned && !i_host_bus_request_n |=> host_owned;
    endproperty
    a_hold: assert property (p_hold) else $error("grant dropped");
    property p_float; s_hand_over |-> o_bus_tristate && !o_bus_granted;
    endproperty
    a_float: assert property (p_float) else $error("pins driven");
    property p_sref; $fell(o_host_bus_grant_n) |-> $past(o_sdram_sr_req);
    endproperty
    a_sref: assert property (p_sref) else $error("no self refresh");
    property p_abort; o_abort |=> !o_bus_granted [*2]; endproperty
    a_abort: assert property (p_abort) else $error("abort kept bus");
    property p_od; !o_core_priority_line_n && !o_dma_priority_line_n;
    endproperty
    a_od: assert property (p_od) else $error("line driven high");
    property p_prio; $rose(i_dma_req) && i_dma_hi_prio |=>
        o_dma_priority_line_oe; endproperty
    a_prio: assert property (p_prio) else $error("no dma priority");
    property p_straps; disable iff (1'b0) i_srst |=> o_straps ==
        {$past(i_bus_lock_indicator_n), $past(i_master_indicator_n)};
    endproperty
    a_straps: assert property (p_straps) else $error("strap lost");
endmodule

bind mpba_arbiter mpba_arbiter_checker u_chk (.*);

// file: sim/mpba_far_side.sv
// Far side: peers, host, SDRAM and pull-ups on the shared wires
`timescale 1ns/100ps
module mpba_far_side
(
    // Clock, reset and scenario commands
    input  wire       i_ref_clk, i_srst, host_want, back_off,
    input  wire       peer_core, peer_dma,
    input  wire [7:0] peer_req,
    input  wire [1:0] strap,
    // Pins driven by the arbiter
    input  wire [7:0] o_bus_request_lines_n, o_bus_request_lines_oe,
    input  wire       o_host_bus_grant_n, o_host_bus_grant_oe,
    input  wire       o_core_priority_line_n, o_core_priority_line_oe,
    input  wire       o_dma_priority_line_n, o_dma_priority_line_oe,
    input  wire       o_master_indicator_n, o_bus_lock_indicator_n,
    input  wire       o_bus_lock_indicator_oe, o_sdram_sr_req,
    // Resolved wire levels seen by the arbiter
    output wire [7:0] i_bus_request_lines_n,
    output wire       i_host_bus_grant_n, i_core_priority_line_n,
    output wire       i_dma_priority_line_n, i_master_indicator_n,
    output wire       i_bus_lock_indicator_n,
    output reg        i_host_bus_request_n = 1'b1,
    output reg        i_back_off_input_n = 1'b1,
    output reg        i_sdram_sr_ack = 1'b0
);
    // Each peer pulls only its own line; unused lines float high
    assign i_bus_request_lines_n = ~(o_bus_request_lines_oe
        & ~o_bus_request_lines_n) & ~peer_req;
    // Grant wire floats high unless the master drives it
    assign i_host_bus_grant_n = o_host_bus_grant_oe
        ? o_host_bus_grant_n : 1'b1;
    // Wired-OR priority lines with pull-ups
    assign i_core_priority_line_n = ~((o_core_priority_line_oe
        & ~o_core_priority_line_n) | peer_core);
    assign i_dma_priority_line_n = ~((o_dma_priority_line_oe
        & ~o_dma_priority_line_n) | peer_dma);
    // Strap levels during reset, device levels afterwards
    assign i_master_indicator_n = i_srst ? strap[0]
        : o_master_indicator_n;
    assign i_bus_lock_indicator_n = i_srst ? strap[1]
        : (o_bus_lock_indicator_oe ? o_bus_lock_indicator_n : 1'b1);
    // Host holds its request while it wants the bus; SDRAM follows
    always @(posedge i_ref_clk)
    begin
        i_host_bus_request_n <= ~host_want;
        i_back_off_input_n   <= ~back_off;
        i_sdram_sr_ack       <= o_sdram_sr_req;
    end
endmodule

// file: sim/tb_multiprocessor_bus_arbitration.sv
// Self-checking bench for the multiprocessor bus arbiter
`timescale 1ns/100ps
module tb_multiprocessor_bus_arbitration;
    // ----------
    // Signals
    // ----------
    reg        i_ref_clk, i_srst, i_core_req, i_dma_req, i_dma_hi_prio;
    reg        i_lock_req, i_xact_busy, host_want, back_off;
    reg        peer_core, peer_dma;
    reg  [2:0] i_processor_identifier, me;
    reg  [7:0] peer_req;
    reg  [1:0] strap;
    wire [7:0] i_bus_request_lines_n, o_bus_request_lines_n;
    wire [7:0] o_bus_request_lines_oe;
    wire       i_host_bus_request_n, i_back_off_input_n, i_host_bus_grant_n;
    wire       o_host_bus_grant_n, o_host_bus_grant_oe, i_sdram_sr_ack;
    wire       i_core_priority_line_n, i_dma_priority_line_n;
    wire       o_core_priority_line_n, o_core_priority_line_oe;
    wire       o_dma_priority_line_n, o_dma_priority_line_oe;
    wire       i_master_indicator_n, i_bus_lock_indicator_n;
    wire       o_master_indicator_n, o_bus_lock_indicator_n;
    wire       o_bus_lock_indicator_oe, o_bus_granted, o_preempt, o_abort;
    wire       o_bus_tristate, o_sdram_sr_req;
    wire [1:0] o_straps;
    wire [3:0] events = {o_bus_granted,
        ~o_host_bus_grant_n & o_host_bus_grant_oe, o_preempt, o_abort};
    integer    fails, n_checks, k;
    reg [31:0] rng;
    reg  [3:0] exp_q[$];
    reg  [3:0] prev, ev;

    mpba_arbiter uut (.*);
    mpba_far_side u_far (.*);

    // ----------
    // Tasks
    // ----------
    task check(input [7:0] seen, input [7:0] want);
        begin
            n_checks = n_checks + 1;
            if (seen !== want)
            begin
                fails = fails + 1;
                $display("wrong value at %0t: %h not %h", $time, seen, want);
            end
        end
    endtask
    task step(input integer n);
        begin
            repeat (n) @(posedge i_ref_clk);
            #1;
        end
    endtask
    // Wait a bounded time for all expected results
    task drain;
        integer w;
        begin
            for (w = 0; w < 40 && exp_q.size() != 0; w = w + 1)
                step(1);
        end
    endtask
    function [31:0] xorshift(input [31:0] s);
        reg [31:0] x;
        begin
            x = s ^ (s << 13);
            x = x ^ (x >> 17);
            xorshift = x ^ (x << 5);
        end
    endfunction
    task do_reset(input [2:0] id);
        begin
            rng = xorshift(rng);
            i_srst = 1'b1;
            i_processor_identifier = id;
            strap = rng[1:0];
            step(4);
            i_srst = 1'b0;
            step(1);
            check(o_straps, strap);
        end
    endtask
    task tally_and_finish;
        begin
            check(8'(exp_q.size()), 8'h00);
            $display("checks %0d fails %0d", n_checks, fails);
            if (fails == 0 && n_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    // ----------
    // Clock, monitor and watchdog
    // ----------
    initial
    begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    // Each new rise of a result takes the oldest note
    always @(negedge i_ref_clk)
    begin
        ev   = events & ~prev;
        prev = events;
        if (ev != 4'h0)
        begin
            if (exp_q.size() == 0)
                check(ev, 4'h0);
            else
                check(ev, exp_q.pop_front());
        end
    end
    initial
    begin
        repeat (3000) @(posedge i_ref_clk);
        fails = fails + 1;
        tally_and_finish;
    end

    // ----------
    // Scenarios
    // ----------
    initial
    begin
        fails = 0;
        n_checks = 0;
        rng = 32'd30;
        prev = 4'h0;
        {i_core_req, i_dma_req, i_dma_hi_prio, i_lock_req} = 4'h0;
        {i_xact_busy, host_want, back_off, peer_core, peer_dma} = 5'h00;
        peer_req = 8'h00;
        // Every identifier drives its own line and wins an idle bus
        for (k = 0; k < 8; k = k + 1)
        begin
            do_reset(k[2:0]);
            // Random mix of core or DMA need, lock and DMA class
            {i_lock_req, i_dma_hi_prio, i_dma_req} = rng[4:2];
            i_core_req = ~rng[2];
            exp_q.push_back(4'h8);
            step(1);
            check(o_bus_request_lines_oe, 8'h01 << k);
            check(o_bus_request_lines_n[k], 1'b0);
            check(o_core_priority_line_oe, i_core_req);
            check(o_dma_priority_line_oe, i_dma_req & i_dma_hi_prio);
            drain;
            check(o_master_indicator_n, 1'b0);
            // Dropping the need makes the owner finish and release
            exp_q.push_back(4'h2);
            {i_core_req, i_dma_req} = 2'h0;
            step(8);
        end
        // Locked ownership handed to the host after the transaction
        me = rng[4:2];
        do_reset(me);
        {i_core_req, i_lock_req, i_xact_busy} = 3'h7;
        exp_q.push_back(4'h8);
        drain;
        step(3);
        check(o_bus_lock_indicator_n, 1'b0);
        host_want = 1'b1;
        exp_q.push_back(4'h2);
        drain;
        step(2 + rng[7:5]);
        check({o_sdram_sr_req, o_host_bus_grant_n}, 2'h1);
        i_xact_busy = 1'b0;
        exp_q.push_back(4'h4);
        drain;
        check({o_bus_tristate, o_sdram_sr_req, o_bus_granted}, 3'h6);
        step(20);
        check(o_host_bus_grant_n, 1'b0);
        host_want = 1'b0;
        exp_q.push_back(4'h8);
        drain;
        // Back-off drops the transaction, then the bus is won again
        i_xact_busy = 1'b1;
        back_off = 1'b1;
        step(1);
        back_off = 1'b0;
        exp_q.push_back(4'h1);
        exp_q.push_back(4'h8);
        drain;
        exp_q.push_back(4'h2);
        {i_core_req, i_lock_req, i_xact_busy} = 3'h0;
        step(8);
        // Peer priority lines against our own DMA traffic
        for (k = 0; k < 3; k = k + 1)
        begin
            i_dma_req = 1'b1;
            i_dma_hi_prio = (k == 2);
            // Locked high-class traffic must ride out the peer's request
            i_lock_req = (k == 2);
            exp_q.push_back(4'h8);
            drain;
            peer_core = (k == 0);
            peer_dma = (k != 0);
            peer_req = 8'h01 << (me ^ 3'h4);
            if (k < 2)
                exp_q.push_back(4'h2);
            step(10);
            check(o_bus_granted, k == 2);
            check(o_host_bus_grant_oe, k == 2);
            check(o_dma_priority_line_oe, k == 2);
            // A kept bus is released once our own need ends
            if (k == 2)
                exp_q.push_back(4'h2);
            {peer_core, peer_dma, i_dma_req, i_lock_req} = 4'h0;
            peer_req = 8'h00;
            step(8);
            drain;
        end
        tally_and_finish;
    end
endmodule
